// ### inc/rsc_pkg.sv
// Shared constants and types for the redundancy state controller.
// Assumes every file that uses them imports the whole package.
package rsc_pkg;

	// Redundancy states, reset state first.
	typedef enum logic [2:0] {
		RSC_NOT_CONFIGURED,
		RSC_STARTING,
		RSC_INACTIVE,
		RSC_ACTIVE,
		RSC_STANDBY
	} rsc_state_t;

	// Bus slot numbering of the two units of the pair.
	localparam int SLOT_W = 4;
	localparam logic [SLOT_W-1:0] SLOT_UNIT_TWO = 4'h2;
	localparam logic [SLOT_W-1:0] SLOT_UNIT_THREE = 4'h3;

	// Scan cycles without a heartbeat before a channel counts as failed.
	localparam int CHAN_MISS_LIMIT = 2;
	localparam int MISS_CNT_W = 4;

endpackage

// ### rtl/rsc_chan_mon.sv
// Watchdog for one synchronism channel, counted in main scan cycles.
// Assumes heartbeat pulses are synchronous to ref_clk and scan_tick marks each scan end.
`timescale 1ns/10ps
`default_nettype none
module rsc_chan_mon
	import rsc_pkg::*;
#(
	parameter int MISS_LIMIT = CHAN_MISS_LIMIT
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Scan timing and channel activity.
	input wire logic scan_tick,
	input wire logic heartbeat,
	// Channel failure level.
	output var logic chan_fail
);

	logic seen_reg;
	logic seen_next;
	logic [MISS_CNT_W-1:0] miss_reg;
	logic [MISS_CNT_W-1:0] miss_next;
	logic fail_next;

	// A heartbeat in the tick cycle itself still counts for the ending scan.
	always_comb begin
		seen_next = seen_reg | heartbeat;
		miss_next = miss_reg;
		if (scan_tick) begin
			seen_next = 1'b0;
			if (seen_reg | heartbeat)
				miss_next = '0;
			else if (miss_reg != MISS_LIMIT[MISS_CNT_W-1:0])
				miss_next = miss_reg + 1'b1; // Saturates so a long outage does not wrap.
		end
		fail_next = (miss_next == MISS_LIMIT[MISS_CNT_W-1:0]);
	end

	// Registers only.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			seen_reg <= 1'b0;
			miss_reg <= '0;
			chan_fail <= 1'b0;
		end else begin
			seen_reg <= seen_next;
			miss_reg <= miss_next;
			chan_fail <= fail_next;
		end
	end

endmodule // rsc_chan_mon
`default_nettype wire

// ### rtl/rsc_ctrl.sv
// Hot-standby redundancy state controller for one unit of a duplicated pair.
// Assumes all inputs are synchronous to ref_clk, scan_tick pulses once per main scan cycle,
// and peer_state and the peer command pulses arrive over the synchronism channels.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - The unit holds one of five states and sits in not configured after reset, when off or when the scan halts.
// - Not configured leads to a starting state whose checks pick inactive, active, stand-by or not configured; slot three stays while the peer starts.
// - Listed failure classes and a maintenance request send the unit to inactive.
// - Only the active unit drives the process while a stand-by unit stays ready to take over.
// - Supply failure, scan halt or loss of both channels swaps roles, the stand-by unit becoming active.
// - A switchover command from display, tool or application on either unit swaps the roles.
// - A single channel fault, data sync fault, project mismatch or firmware mismatch keeps the unit out of stand-by.
// - A leave-stand-by command from any source on either unit drives the stand-by unit to inactive.
// - A switchover completes within one to three scan cycles.
// - Channels A and B are each watched for failure on their own.
// - The slot number tells the unit whether it is the slot-two or the slot-three unit.
module rsc_ctrl
	import rsc_pkg::*;
#(
	parameter int MISS_LIMIT = CHAN_MISS_LIMIT
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Unit health and scan timing.
	input wire logic power_ok,
	input wire logic main_scan_task,
	input wire logic scan_tick,
	input wire logic [SLOT_W-1:0] slot_id,
	// Failure indications.
	input wire logic fail_class,
	input wire logic maint_req,
	input wire logic data_sync_fail,
	input wire logic project_mismatch,
	input wire logic fw_incompat,
	input wire logic restart_req,
	// Synchronism channels and partner view.
	input wire logic chan_a_beat,
	input wire logic chan_b_beat,
	input wire rsc_state_t peer_state,
	input wire logic peer_cmd_switch,
	input wire logic peer_cmd_leave,
	// Local command pulses.
	input wire logic cmd_switch_disp,
	input wire logic cmd_switch_tool,
	input wire logic cmd_switch_app,
	input wire logic cmd_leave_disp,
	input wire logic cmd_leave_tool,
	input wire logic cmd_leave_app,
	// State and role outputs.
	output var rsc_state_t red_state,
	output var logic drive_process,
	output var logic unit_slot_two,
	output var logic unit_slot_three,
	output var logic chan_a_fail,
	output var logic chan_b_fail,
	// Commands forwarded to the partner.
	output var logic fwd_switch,
	output var logic fwd_leave
);

	logic [1:0] beat;
	logic [1:0] chan_fail;
	logic both_lost;
	logic any_lost;
	logic slot_ok;
	logic sw_pend_reg;
	logic sw_pend_next;
	logic lv_pend_reg;
	logic lv_pend_next;
	logic sw_now;
	logic lv_now;
	logic standby_block;
	logic halted;
	rsc_state_t state_next;
	logic fwd_switch_next;
	logic fwd_leave_next;
	logic drive_next;

	assign beat = {chan_b_beat, chan_a_beat};

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		rsc_chan_mon #(
			.MISS_LIMIT(MISS_LIMIT)
		) u_mon (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.scan_tick(scan_tick),
			.heartbeat(beat[ch]),
			.chan_fail(chan_fail[ch])
		);
	end

	assign chan_a_fail = chan_fail[0];
	assign chan_b_fail = chan_fail[1];
	assign both_lost = &chan_fail;
	assign any_lost = |chan_fail;
	assign halted = !power_ok || !main_scan_task;
	assign slot_ok = (slot_id == SLOT_UNIT_TWO) || (slot_id == SLOT_UNIT_THREE);

	// Commands are pulses that may come at any time; they wait for the scan end.
	// A pulse in the tick cycle is consumed at once, so clearing never loses one.
	always_comb begin
		sw_now = sw_pend_reg | cmd_switch_disp | cmd_switch_tool | cmd_switch_app;
		lv_now = lv_pend_reg | cmd_leave_disp | cmd_leave_tool | cmd_leave_app;
		sw_pend_next = scan_tick ? 1'b0 : sw_now;
		lv_pend_next = scan_tick ? 1'b0 : lv_now;
	end

	assign standby_block = any_lost || data_sync_fail || project_mismatch || fw_incompat || fail_class || maint_req;

	// State decision, evaluated at the scan end; a halt forces not configured in any cycle.
	always_comb begin
		state_next = red_state;
		fwd_switch_next = 1'b0;
		fwd_leave_next = 1'b0;
		if (halted) begin
			state_next = RSC_NOT_CONFIGURED;
		end else if (scan_tick) begin
			unique case (red_state)
				RSC_NOT_CONFIGURED: begin
					state_next = RSC_STARTING;
				end
				RSC_STARTING: begin
					if (!slot_ok)
						state_next = RSC_NOT_CONFIGURED;
					else if (fail_class || maint_req)
						state_next = RSC_INACTIVE;
					else if (both_lost)
						state_next = RSC_ACTIVE;
					else if (peer_state == RSC_ACTIVE)
						state_next = standby_block ? RSC_INACTIVE : RSC_STANDBY;
					else if (peer_state != RSC_STARTING || slot_id == SLOT_UNIT_TWO)
						state_next = RSC_ACTIVE; // Slot two wins a simultaneous start.
				end
				RSC_ACTIVE: begin
					if (fail_class || maint_req)
						state_next = RSC_INACTIVE;
					else if ((sw_now || peer_cmd_switch) && peer_state == RSC_STANDBY)
						state_next = RSC_INACTIVE;
					else if (!both_lost && peer_state == RSC_ACTIVE && slot_id == SLOT_UNIT_THREE)
						state_next = RSC_INACTIVE; // Two actives with a channel up do not persist; slot three yields.
					fwd_leave_next = lv_now;
				end
				RSC_STANDBY: begin
					if (both_lost || peer_state == RSC_NOT_CONFIGURED || peer_state == RSC_INACTIVE)
						state_next = RSC_ACTIVE;
					else if (standby_block)
						state_next = RSC_INACTIVE;
					else if (lv_now || peer_cmd_leave)
						state_next = RSC_INACTIVE;
					// forward switchover to the active partner
					fwd_switch_next = sw_now;
				end
				RSC_INACTIVE: begin
					if (restart_req && !maint_req && !fail_class)
						state_next = RSC_STARTING;
					fwd_switch_next = sw_now;
					fwd_leave_next = lv_now;
				end
			endcase
		end
		drive_next = (state_next == RSC_ACTIVE);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			red_state <= RSC_NOT_CONFIGURED;
			drive_process <= 1'b0;
			sw_pend_reg <= 1'b0;
			lv_pend_reg <= 1'b0;
			fwd_switch <= 1'b0;
			fwd_leave <= 1'b0;
		end else begin
			red_state <= state_next;
			drive_process <= drive_next;
			sw_pend_reg <= sw_pend_next;
			lv_pend_reg <= lv_pend_next;
			fwd_switch <= fwd_switch_next;
			fwd_leave <= fwd_leave_next;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			unit_slot_two <= 1'b0;
			unit_slot_three <= 1'b0;
		end else begin
			unit_slot_two <= (slot_id == SLOT_UNIT_TWO);
			unit_slot_three <= (slot_id == SLOT_UNIT_THREE);
		end
	end

	// Checks on the state behaviour.
	property p_halt_ncfg;
		@(posedge ref_clk) disable iff (!nrst) halted |=> red_state == RSC_NOT_CONFIGURED;
	endproperty
	a_halt_ncfg: assert property (p_halt_ncfg) else $error("halted unit not in not configured");

	property p_ncfg_start;
		@(posedge ref_clk) disable iff (!nrst)
			(red_state == RSC_NOT_CONFIGURED && scan_tick && !halted) |=> red_state == RSC_STARTING;
	endproperty
	a_ncfg_start: assert property (p_ncfg_start) else $error("not configured did not start");

	property p_fail_inactive;
		@(posedge ref_clk) disable iff (!nrst)
			(red_state == RSC_ACTIVE && scan_tick && !halted && fail_class) |=> red_state == RSC_INACTIVE;
	endproperty
	a_fail_inactive: assert property (p_fail_inactive) else $error("active unit ignored failure");

	property p_drive_active;
		@(posedge ref_clk) disable iff (!nrst) drive_process == (red_state == RSC_ACTIVE);
	endproperty
	a_drive_active: assert property (p_drive_active) else $error("process drive and state disagree");

	property p_both_lost;
		@(posedge ref_clk) disable iff (!nrst)
			(red_state == RSC_STANDBY && scan_tick && !halted && both_lost) |=> drive_process;
	endproperty
	a_both_lost: assert property (p_both_lost) else $error("stand-by did not take over");

	property p_block_standby;
		@(posedge ref_clk) disable iff (!nrst)
			(scan_tick && !both_lost && any_lost) |=> red_state != RSC_STANDBY;
	endproperty
	a_block_standby: assert property (p_block_standby) else $error("stand-by kept with a channel down");

	property p_leave_cmd;
		@(posedge ref_clk) disable iff (!nrst)
			(red_state == RSC_STANDBY && scan_tick && !halted && peer_cmd_leave && !both_lost
				&& peer_state == RSC_ACTIVE) |=> red_state == RSC_INACTIVE;
	endproperty
	a_leave_cmd: assert property (p_leave_cmd) else $error("stand-by ignored leave command");

	property p_once_per_scan;
		@(posedge ref_clk) disable iff (!nrst)
			(!scan_tick && !halted) |=> $stable(red_state);
	endproperty
	a_once_per_scan: assert property (p_once_per_scan) else $error("state changed between scan ends");

	property p_switch_cmd;
		@(posedge ref_clk) disable iff (!nrst)
			(red_state == RSC_ACTIVE && scan_tick && peer_cmd_switch && !halted && !fail_class && !maint_req
				&& peer_state == RSC_STANDBY) |=> !drive_process;
	endproperty
	a_switch_cmd: assert property (p_switch_cmd) else $error("active unit kept control after command");

endmodule // rsc_ctrl
`default_nettype wire

// ### rtl/rsc_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### bench/rsc_peer_model.sv
// Partner unit model: state seen by the unit, heartbeats and forwarded commands.
// Assumes scan_tick and the forwarded pulses are synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module rsc_peer_model
	import rsc_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic nrst,
	// Bench control.
	input wire logic follow,
	input wire rsc_state_t set_state,
	input wire logic [1:0] beat_en,
	input wire logic psw,
	input wire logic plv,
	// From the unit.
	input wire logic scan_tick,
	input wire logic fwd_switch,
	input wire logic fwd_leave,
	// To the unit.
	output var rsc_state_t peer_state,
	output var logic chan_a_beat,
	output var logic chan_b_beat,
	output var logic peer_cmd_switch,
	output var logic peer_cmd_leave
);
	// The partner follows the bench unless it runs on its own to obey forwarded commands.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			peer_state <= RSC_NOT_CONFIGURED;
			{chan_a_beat, chan_b_beat, peer_cmd_switch, peer_cmd_leave} <= 4'h0;
		end else begin
			if (follow)
				peer_state <= set_state;
			else if ((fwd_switch && peer_state == RSC_ACTIVE) || (fwd_leave && peer_state == RSC_STANDBY))
				peer_state <= RSC_INACTIVE;
			chan_a_beat <= beat_en[0] & scan_tick;
			chan_b_beat <= beat_en[1] & scan_tick;
			peer_cmd_switch <= psw;
			peer_cmd_leave <= plv;
		end
	end
endmodule // rsc_peer_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the redundancy state controller.
// Assumes the partner model stands in for the peer unit.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import rsc_pkg::*;
;
	logic ref_clk = 0, nrst = 0, power_ok = 1, run = 1, scan_tick = 0, restart_req = 0;
	logic follow = 1, psw = 0, plv = 0, fwd_switch, fwd_leave;
	logic [1:0] fm = 0, ben = 2'h3;
	logic [2:0] blk = 0;
	logic [5:0] cmds = 0;
	logic [SLOT_W-1:0] slot_id = SLOT_UNIT_TWO;
	logic ca, cb, pcs, pcl, drive_process, u2, u3, caf, cbf;
	rsc_state_t pstate = RSC_NOT_CONFIGURED, peer_state, red_state;
	int fails = 0, checked = 0, n;

	// A 4 ns clock.
	always #2 ref_clk = ~ref_clk;

	rsc_peer_model peer (.ref_clk(ref_clk), .nrst(nrst), .follow(follow), .set_state(pstate), .beat_en(ben),
		.psw(psw), .plv(plv), .scan_tick(scan_tick), .fwd_switch(fwd_switch), .fwd_leave(fwd_leave),
		.peer_state(peer_state), .chan_a_beat(ca), .chan_b_beat(cb), .peer_cmd_switch(pcs), .peer_cmd_leave(pcl));

	rsc_ctrl #(.MISS_LIMIT(2)) DUT (.ref_clk(ref_clk), .nrst(nrst), .power_ok(power_ok), .main_scan_task(run),
		.scan_tick(scan_tick), .slot_id(slot_id), .fail_class(fm[0]), .maint_req(fm[1]),
		.data_sync_fail(blk[0]), .project_mismatch(blk[1]), .fw_incompat(blk[2]), .restart_req(restart_req),
		.chan_a_beat(ca), .chan_b_beat(cb), .peer_state(peer_state), .peer_cmd_switch(pcs),
		.peer_cmd_leave(pcl), .cmd_switch_disp(cmds[0]), .cmd_switch_tool(cmds[1]), .cmd_switch_app(cmds[2]),
		.cmd_leave_disp(cmds[3]), .cmd_leave_tool(cmds[4]), .cmd_leave_app(cmds[5]), .red_state(red_state),
		.drive_process(drive_process), .unit_slot_two(u2), .unit_slot_three(u3), .chan_a_fail(caf),
		.chan_b_fail(cbf), .fwd_switch(fwd_switch), .fwd_leave(fwd_leave));

	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic st(input rsc_state_t e);
		chk(red_state, e);
		chk({2'b00, drive_process}, {2'b00, e == RSC_ACTIVE});
	endtask

	// One main scan: a single tick pulse, then look once its edge has landed.
	task automatic scan();
		@(posedge ref_clk) scan_tick <= 1;
		@(posedge ref_clk) scan_tick <= 0;
		@(negedge ref_clk);
	endtask

	task automatic pulse(input int i);
		@(posedge ref_clk) cmds <= 6'h01 << i;
		@(posedge ref_clk) cmds <= 6'h00;
	endtask

	// Dropping power_ok takes the unit to not configured without a tick.
	task automatic go(input rsc_state_t p, input rsc_state_t e);
		@(posedge ref_clk) power_ok <= 0;
		@(posedge ref_clk) power_ok <= 1;
		pstate <= p;
		scan();
		scan();
		st(e);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1;
		@(negedge ref_clk);
		st(RSC_NOT_CONFIGURED);
		scan();
		st(RSC_STARTING);
		scan();
		st(RSC_ACTIVE);
		chk({2'b00, u2}, 3'h1);
		$display("test start done");
		for (n = 0; n < 4; n++) begin
			go(RSC_STANDBY, RSC_ACTIVE);
			if (n < 3) pulse(n);
			else psw <= 1;
			scan();
			psw <= 0;
			st(RSC_INACTIVE);
		end
		for (n = 0; n < 2; n++) begin
			go(RSC_NOT_CONFIGURED, RSC_ACTIVE);
			@(posedge ref_clk) fm <= 2'h1 << n;
			scan();
			@(posedge ref_clk) fm <= 2'h0;
			st(RSC_INACTIVE);
		end
		@(posedge ref_clk) restart_req <= 1'b1;
		scan();
		@(posedge ref_clk) restart_req <= 1'b0;
		st(RSC_STARTING);
		$display("test switch done");
		for (n = 0; n < 4; n++) begin
			go(RSC_ACTIVE, RSC_STANDBY);
			if (n < 3) pulse(n + 3);
			else plv <= 1;
			scan();
			plv <= 0;
			st(RSC_INACTIVE);
		end
		for (n = 0; n < 4; n++) begin
			go(RSC_ACTIVE, RSC_STANDBY);
			@(posedge ref_clk) if (n < 3) blk <= 3'h1 << n;
			else ben <= 2'h2;
			repeat (4) scan();
			st(RSC_INACTIVE);
			chk({1'b0, caf, cbf}, {1'b0, n == 3, 1'b0});
			@(posedge ref_clk) blk <= 3'h0;
			ben <= 2'h3;
			repeat (2) scan();
		end
		$display("test leave done");
		go(RSC_ACTIVE, RSC_STANDBY);
		pstate <= RSC_INACTIVE;
		scan();
		st(RSC_ACTIVE);
		go(RSC_ACTIVE, RSC_STANDBY);
		ben <= 2'h0;
		repeat (4) scan();
		st(RSC_ACTIVE);
		chk({1'b0, caf, cbf}, 3'h3);
		ben <= 2'h3;
		repeat (2) scan();
		@(posedge ref_clk) run <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		st(RSC_NOT_CONFIGURED);
		@(posedge ref_clk) run <= 1'b1;
		go(RSC_ACTIVE, RSC_STANDBY);
		follow <= 0;
		pulse(0);
		scan();
		chk({2'b00, fwd_switch}, 3'h1);
		n = 0;
		while (red_state !== RSC_ACTIVE && n < 3) begin
			scan();
			n++;
		end
		st(RSC_ACTIVE);
		pulse(3);
		scan();
		chk({2'b00, fwd_leave}, 3'h1);
		follow <= 1;
		$display("test failover done");
		@(posedge ref_clk) slot_id <= SLOT_UNIT_THREE;
		go(RSC_ACTIVE, RSC_STANDBY);
		chk({2'b00, u3}, 3'h1);
		@(posedge ref_clk) slot_id <= 4'h5;
		go(RSC_NOT_CONFIGURED, RSC_NOT_CONFIGURED);
		$display("test slot done");
		report_and_stop();
	end

	// Watchdog well past the expected run length.
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
